//--- srf_defines.svh
// Constants of the sinc3 rate filter control: register map, field positions,
// reset value, rates and timing counts. Definitions only; included by name.
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH

// Register byte addresses
`define SRF_FLT_CTRL_ADDR      32'hFFFF0514
`define SRF_STATUS_ADDR        32'hFFFF05F0
`define SRF_RESULT0_ADDR       32'hFFFF05F4
`define SRF_RESULT1_ADDR       32'hFFFF05F8
`define SRF_FLT_CTRL_RST       16'h0007

// Filter control fields
`define SRF_CHOP_BIT           15
`define SRF_RAVG_BIT           14
`define SRF_AF_MSB             13
`define SRF_AF_LSB             8
`define SRF_NOTCH_BIT          7
`define SRF_SF_MSB             6
`define SRF_SF_LSB             0
`define SRF_SF_60HZ            7'h7E
`define SRF_SF_50HZ            7'h7F

// Status fields
`define SRF_ST_READY_LSB       0
`define SRF_ST_SETTLED_BIT     2
`define SRF_ST_STARTING_BIT    3
`define SRF_ST_CHOP_PHASE_BIT  4

// Modulator rates and filter structure
`define SRF_MOD_HZ_NORMAL      512000
`define SRF_MOD_HZ_LOWPWR      131072
`define SRF_SINC_BASE          64
`define SRF_COMB_TAPS          4
`define SRF_SUB_PER_SF         (`SRF_SINC_BASE / `SRF_COMB_TAPS)
`define SRF_RATE_60HZ          60
`define SRF_RATE_50HZ          50
`define SRF_POST_OFFSET        3
`define SRF_CHOP_GAP_TICKS     3
`define SRF_MIN_RATE_NORMAL    4
`define SRF_MIN_RATE_LOWPWR    1

// Settling, in output periods
`define SRF_SETTLE_PLAIN       3'h3
`define SRF_SETTLE_RAVG        3'h4
`define SRF_SETTLE_AF          3'h1
`define SRF_SETTLE_BOTH        3'h2
`define SRF_SETTLE_CHOP        3'h2

// Timing on the system clock
`define SRF_CLK_HZ             250000000
`define SRF_CLK_MHZ            250
`define SRF_STARTUP_US         60
`define SRF_STARTUP_CYC        (`SRF_STARTUP_US * `SRF_CLK_MHZ)

`endif

//--- srf_pkg.sv
// Types shared by the sinc3 rate filter control modules.
// Assumes srf_defines.svh for all numeric constants.
package srf_pkg;

    typedef enum logic [2:0] {
        SRF_ST_START = 3'b001,
        SRF_ST_RUN   = 3'b010,
        SRF_ST_GAP   = 3'b100
    } srf_state_t;

endpackage

//--- srf_tick_gen.sv
// Modulator sample tick: a phase accumulator that yields the 512 kHz or
// low power 131072 Hz sample rate exactly on average from the system clock.
// Assumes low_power_i is a level from logic on the same clock.
`timescale 1ns/10ps
`include "srf_defines.svh"

module srf_tick_gen
    import srf_pkg::*;
#(
    parameter int CLK_HZ = `SRF_CLK_HZ
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic low_power_i,
    output logic      tick_o
);

    typedef struct packed {
        logic [28:0] acc;
        logic        tick;
    } srf_tick_state_t;

    srf_tick_state_t s;
    srf_tick_state_t next_s;

    always_comb begin
        logic [28:0] step;
        logic [28:0] sum;
        step   = low_power_i ? 29'(`SRF_MOD_HZ_LOWPWR) : 29'(`SRF_MOD_HZ_NORMAL);
        sum    = s.acc + step;
        next_s = s;
        next_s.tick = 1'b0;
        if (sum >= 29'(CLK_HZ)) begin
            next_s.acc  = sum - 29'(CLK_HZ);
            next_s.tick = 1'b1;
        end else begin
            next_s.acc = sum;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;

endmodule // srf_tick_gen

//--- srf_sinc3.sv
// One sinc3 decimator: three integrators at the modulator rate, three combs
// at four times the output rate. Comb delays of four sub-samples give the
// plain sinc3; a third comb of three puts a second notch at 4/3 of the first.
// Assumes bit_i is already synchronised and sample_en_i is a one-cycle tick.
`timescale 1ns/10ps
`include "srf_defines.svh"

module srf_sinc3
    import srf_pkg::*;
#(
    parameter int ACC_W = 42
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             clr_i,
    input  wire logic             sample_en_i,
    input  wire logic             bit_i,
    input  wire logic [15:0]      sub_len_i,
    input  wire logic             second_notch_on_i,
    output logic                  vld_o,
    output logic [ACC_W-1:0]      data_o
);

    typedef struct packed {
        logic [2:0][ACC_W-1:0]      integ;
        logic [2:0][3:0][ACC_W-1:0] hist;
        logic [15:0]                sub_cnt;
        logic [1:0]                 phase;
        logic [ACC_W-1:0]           data;
        logic                       vld;
    } srf_sinc_state_t;

    srf_sinc_state_t s;
    srf_sinc_state_t next_s;

    always_comb begin
        logic [ACC_W-1:0] c;
        logic [ACC_W-1:0] dly;
        c      = '0;
        dly    = '0;
        next_s = s;
        next_s.vld = 1'b0;
        if (clr_i) begin
            next_s = '0;
        end else if (sample_en_i) begin
            next_s.integ[0] = s.integ[0] + (bit_i ? ACC_W'(1) : {ACC_W{1'b1}});
            next_s.integ[1] = s.integ[1] + next_s.integ[0];
            next_s.integ[2] = s.integ[2] + next_s.integ[1];
            if (s.sub_cnt >= sub_len_i - 16'h0001) begin
                next_s.sub_cnt = '0;
                c = next_s.integ[2];
                for (int k = 0; k < 3; k++) begin
                    dly = (k == 2 && second_notch_on_i) ? s.hist[k][2] : s.hist[k][3];
                    next_s.hist[k] = {s.hist[k][2:0], c};
                    c = c - dly;
                end
                next_s.phase = s.phase + 2'h1;
                if (s.phase == 2'h3) begin
                    next_s.data = c;
                    next_s.vld  = 1'b1;
                end
            end else begin
                next_s.sub_cnt = s.sub_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign vld_o  = s.vld;
    assign data_o = s.data;

endmodule // srf_sinc3

//--- srf_filter_ctrl.sv
// Sinc3 rate filter control for the primary and auxiliary converters: the
// filter control register, two sinc3 decimators, post averaging, running
// average, system chopping, settling and start-up gating of results.
// Assumes modulator bitstreams come from outside the clock domain and the
// register port master follows the one-cycle strobe protocol.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "srf_defines.svh"

module srf_filter_ctrl
    import srf_pkg::*;
#(
    parameter int STARTUP_CYC = `SRF_STARTUP_CYC,
    parameter int ACC_W       = 42
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        low_power_i,
    input  wire logic [1:0]  mod_bit_i,
    output logic             chop_phase_o,
    output logic             conv_reset_o,
    output logic      [31:0] result_primary_o,
    output logic      [31:0] result_aux_o,
    output logic      [1:0]  result_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic [15:0] sub_len(input logic [6:0] sf, input logic lp);
        logic [15:0] n;
        n = 16'(`SRF_SUB_PER_SF) * (16'(sf) + 16'h0001);
        if (sf == `SRF_SF_60HZ) begin
            n = lp ? 16'(`SRF_MOD_HZ_LOWPWR / (`SRF_RATE_60HZ * `SRF_COMB_TAPS))
                   : 16'(`SRF_MOD_HZ_NORMAL / (`SRF_RATE_60HZ * `SRF_COMB_TAPS));
        end else if (sf == `SRF_SF_50HZ) begin
            n = lp ? 16'(`SRF_MOD_HZ_LOWPWR / (`SRF_RATE_50HZ * `SRF_COMB_TAPS))
                   : 16'(`SRF_MOD_HZ_NORMAL / (`SRF_RATE_50HZ * `SRF_COMB_TAPS));
        end
        return n;
    endfunction

    function automatic logic [2:0] settle_need(input logic chop, input logic ravg,
                                               input logic af_nz);
        logic [2:0] n;
        if (chop) begin
            n = `SRF_SETTLE_CHOP;
        end else if (ravg && af_nz) begin
            n = `SRF_SETTLE_BOTH;
        end else if (ravg) begin
            n = `SRF_SETTLE_RAVG;
        end else if (af_nz) begin
            n = `SRF_SETTLE_AF;
        end else begin
            n = `SRF_SETTLE_PLAIN;
        end
        return n;
    endfunction

    function automatic logic [17:0] max_ticks(input logic lp);
        return lp ? 18'(`SRF_MOD_HZ_LOWPWR / `SRF_MIN_RATE_LOWPWR)
                  : 18'(`SRF_MOD_HZ_NORMAL / `SRF_MIN_RATE_NORMAL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        srf_state_t       st;
        logic [15:0]      ctrl;
        logic [31:0]      rdata;
        logic [15:0]      start_cnt;
        logic [1:0]       gap_cnt;
        logic             chop_pol;
        logic [6:0]       post_cnt;
        logic [17:0]      wd_cnt;
        logic [1:0][31:0] sum;
        logic [1:0][31:0] prev;
        logic             have_prev;
        logic [2:0]       conv_cnt;
        logic             settled;
        logic [1:0][31:0] result;
        logic [1:0]       res_valid;
        logic [1:0]       ready;
        logic [1:0]       sync1;
        logic [1:0]       sync2;
    } srf_ctrl_state_t;

    srf_ctrl_state_t s;
    srf_ctrl_state_t next_s;

    logic                  tick;
    logic                  sample_en;
    logic                  sinc_clr;
    logic [1:0]            sinc_vld;
    logic [1:0][ACC_W-1:0] sinc_data;
    logic                  chop_on;
    logic                  ravg_on;
    logic [5:0]            af;
    logic [15:0]           sub_n;
    logic                  restart;

    assign chop_on = s.ctrl[`SRF_CHOP_BIT];
    assign ravg_on = s.ctrl[`SRF_RAVG_BIT] | chop_on;
    assign af      = s.ctrl[`SRF_AF_MSB:`SRF_AF_LSB];
    assign sub_n   = sub_len(s.ctrl[`SRF_SF_MSB:`SRF_SF_LSB], low_power_i);

    // Only a write that changes the value restarts the converters
    assign restart = wr_i && (addr_i == `SRF_FLT_CTRL_ADDR)
                     && (wdata_i[15:0] != s.ctrl);

    // Chop settling gap and start-up both hold the decimators
    assign sample_en = tick && (s.st == SRF_ST_RUN);
    assign sinc_clr  = (s.st == SRF_ST_START);

    ////////////////////////////////////////////////////////////////////////////
    // Sample tick and decimators

    srf_tick_gen u_tick (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .low_power_i (low_power_i),
        .tick_o      (tick)
    );

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        srf_sinc3 #(
            .ACC_W (ACC_W)
        ) u_sinc (
            .sys_clk_i   (sys_clk_i),
            .rst_n_i     (rst_n_i),
            .ce_i        (ce_i),
            .clr_i       (sinc_clr),
            .sample_en_i (sample_en),
            .bit_i       (s.sync2[ch] ^ s.chop_pol),
            .sub_len_i   (sub_n),
            .second_notch_on_i    (s.ctrl[`SRF_NOTCH_BIT]),
            .vld_o       (sinc_vld[ch]),
            .data_o      (sinc_data[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [6:0]       target;
        logic [2:0]       cnt_n;
        logic             done;
        logic [31:0]      smp;
        logic [31:0]      conv;
        logic [31:0]      outv;
        target = '0;
        cnt_n  = '0;
        done   = 1'b0;
        smp    = '0;
        conv   = '0;
        outv   = '0;
        next_s = s;
        next_s.res_valid = '0;
        next_s.rdata     = '0;
        next_s.sync1     = mod_bit_i;
        next_s.sync2     = s.sync1;

        // Register reads; reading a result clears its ready flag
        if (rd_i) begin
            if (addr_i == `SRF_FLT_CTRL_ADDR) begin
                next_s.rdata = {16'h0000, s.ctrl};
            end else if (addr_i == `SRF_STATUS_ADDR) begin
                next_s.rdata = {27'h0000000, s.chop_pol, (s.st == SRF_ST_START),
                                s.settled, s.ready};
            end else if (addr_i == `SRF_RESULT0_ADDR) begin
                next_s.rdata    = s.result[0];
                next_s.ready[0] = 1'b0;
            end else if (addr_i == `SRF_RESULT1_ADDR) begin
                next_s.rdata    = s.result[1];
                next_s.ready[1] = 1'b0;
            end
        end

        // Post-filter length: plain sinc3 delivers every output
        target = (chop_on || af != 6'h00) ? 7'(af) + 7'(`SRF_POST_OFFSET)
                                          : 7'h01;

        unique case (s.st)
            SRF_ST_START: begin
                if (s.start_cnt >= 16'(STARTUP_CYC - 1)) begin
                    next_s.st        = SRF_ST_RUN;
                    next_s.start_cnt = '0;
                end else begin
                    next_s.start_cnt = s.start_cnt + 16'h0001;
                end
            end
            SRF_ST_RUN: begin
                if (tick && s.wd_cnt < max_ticks(low_power_i)) begin
                    next_s.wd_cnt = s.wd_cnt + 18'h00001;
                end
                if (sinc_vld[0]) begin
                    // A conversion that runs past the slowest period ends early
                    done = (s.post_cnt + 7'h01 >= target)
                           || (s.wd_cnt >= max_ticks(low_power_i));
                    next_s.post_cnt = done ? 7'h00 : s.post_cnt + 7'h01;
                    if (done) begin
                        next_s.wd_cnt = '0;
                    end
                    cnt_n = (s.conv_cnt == 3'h7) ? 3'h7 : s.conv_cnt + 3'h1;
                    for (int ch = 0; ch < 2; ch++) begin
                        smp = {{8{sinc_data[ch][ACC_W-1]}}, sinc_data[ch][ACC_W-1 -: 24]};
                        if (s.chop_pol) begin
                            smp = 32'h00000000 - smp;
                        end
                        conv = s.sum[ch] + smp;
                        next_s.sum[ch] = done ? 32'h00000000 : conv;
                        if (done) begin
                            outv = conv;
                            if (ravg_on && s.have_prev) begin
                                outv = 32'(($signed(conv) + $signed(s.prev[ch])) >>> 1);
                            end
                            next_s.prev[ch] = conv;
                            if (cnt_n >= settle_need(chop_on, s.ctrl[`SRF_RAVG_BIT],
                                                     af != 6'h00)) begin
                                next_s.result[ch]    = outv;
                                next_s.res_valid[ch] = 1'b1;
                                next_s.ready[ch]     = 1'b1;
                            end
                        end
                    end
                    if (done) begin
                        next_s.have_prev = 1'b1;
                        next_s.conv_cnt  = cnt_n;
                        if (cnt_n >= settle_need(chop_on, s.ctrl[`SRF_RAVG_BIT],
                                                 af != 6'h00)) begin
                            next_s.settled = 1'b1;
                        end
                        if (chop_on) begin
                            // Flip the input sense, then let the modulators settle
                            next_s.chop_pol = ~s.chop_pol;
                            next_s.st       = SRF_ST_GAP;
                            next_s.gap_cnt  = '0;
                        end
                    end
                end
            end
            SRF_ST_GAP: begin
                if (tick) begin
                    if (s.gap_cnt == 2'(`SRF_CHOP_GAP_TICKS - 1)) begin
                        next_s.st      = SRF_ST_RUN;
                        next_s.gap_cnt = '0;
                    end else begin
                        next_s.gap_cnt = s.gap_cnt + 2'h1;
                    end
                end
            end
        endcase

        // Restart: throw away every partial sum and the settling history
        if (restart) begin
            next_s.ctrl      = wdata_i[15:0];
            next_s.st        = SRF_ST_START;
            next_s.start_cnt = '0;
            next_s.gap_cnt   = '0;
            next_s.chop_pol  = 1'b0;
            next_s.post_cnt  = '0;
            next_s.wd_cnt    = '0;
            next_s.sum       = '0;
            next_s.prev      = '0;
            next_s.have_prev = 1'b0;
            next_s.conv_cnt  = '0;
            next_s.settled   = 1'b0;
            next_s.res_valid = '0;
            next_s.ready     = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s      <= '0;
            s.st   <= SRF_ST_START;
            s.ctrl <= `SRF_FLT_CTRL_RST;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_o          = s.rdata;
    assign chop_phase_o     = s.chop_pol;
    assign conv_reset_o     = (s.st == SRF_ST_START);
    assign result_primary_o = s.result[0];
    assign result_aux_o     = s.result[1];
    assign result_valid_o   = s.res_valid;

endmodule // srf_filter_ctrl

//--- srf_mod_model.sv
// Modulator pair model: mid-scale toggling until run_i, then full scale
// (primary all +1, auxiliary all -1). Bits change off the system clock.
`timescale 1ns/10ps
module srf_mod_model #(
    parameter int BIT_NS = 1953
) (
    input  wire logic       run_i,
    output logic      [1:0] mod_bit_o
);
    initial begin
        mod_bit_o = 2'h1;
        forever begin
            #(BIT_NS);
            mod_bit_o = run_i ? 2'h1 : ~mod_bit_o;
        end
    end
endmodule // srf_mod_model

//--- srf_filter_ctrl_asserts.sv
// Port checker for srf_filter_ctrl, bound into every instance.
// Assumes ce_i stays high and one clock domain.
`timescale 1ns/10ps
`include "srf_defines.svh"
module srf_filter_ctrl_asserts #(
    parameter int STARTUP_CYC = 20
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        conv_reset_o,
    input wire logic [31:0] result_primary_o,
    input wire logic [1:0]  result_valid_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////
    logic [15:0] ctrl;
    logic [16:0] since;
    wire logic   ctrl_hit = addr_i == `SRF_FLT_CTRL_ADDR;
    wire logic   mapped   = ctrl_hit || addr_i == `SRF_STATUS_ADDR
                            || addr_i == `SRF_RESULT0_ADDR || addr_i == `SRF_RESULT1_ADDR;
    // Cycles since the last restart ended, saturating
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl  <= `SRF_FLT_CTRL_RST;
            since <= '0;
        end else begin
            if (wr_i && ctrl_hit)
                ctrl <= wdata_i[15:0];
            since <= conv_reset_o ? '0 : since + {16'h0, since != 17'h1FFFF};
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_idle_rdata; !rd_i |=> rdata_o == 32'h0; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("rdata not zero");
    property p_ctrl_read; rd_i && ctrl_hit |=> rdata_o == {16'h0, ctrl}; endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read");
    property p_unmapped; rd_i && !mapped |=> rdata_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_restart; wr_i && ctrl_hit && wdata_i[15:0] != ctrl |=> conv_reset_o; endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_same_keep;
        wr_i && ctrl_hit && wdata_i[15:0] == ctrl && !conv_reset_o |=> !conv_reset_o;
    endproperty
    a_same_keep: assert property (p_same_keep) else $error("needless restart");
    property p_restart_hold; $rose(conv_reset_o) |-> conv_reset_o [*8]; endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("short restart");
    property p_no_old; conv_reset_o |-> result_valid_o == 2'h0; endproperty
    a_no_old: assert property (p_no_old) else $error("valid in restart");
    property p_lockstep;
        result_valid_o != 2'h0 |-> result_valid_o == 2'h3 ##1 result_valid_o == 2'h0;
    endproperty
    a_lockstep: assert property (p_lockstep) else $error("valid pulse");
    property p_settle; result_valid_o != 2'h0 |-> since >= 17'd90000; endproperty
    a_settle: assert property (p_settle) else $error("early result");
    property p_hold; result_valid_o == 2'h0 |-> $stable(result_primary_o); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
endmodule // srf_filter_ctrl_asserts
bind srf_filter_ctrl srf_filter_ctrl_asserts #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_reset_o(conv_reset_o),
    .result_primary_o(result_primary_o), .result_valid_o(result_valid_o));

//--- srf_filter_ctrl_tb_top.sv
// Testbench for srf_filter_ctrl: register port, restarts and one settled
// conversion from a full-scale modulator model. Short start-up parameter.
`timescale 1ns/10ps
`include "srf_defines.svh"
module srf_filter_ctrl_tb_top;
    localparam int STARTUP = 20;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        run       = 1'b0;
    logic [31:0] addr_i    = '0;
    logic [31:0] wdata_i   = '0;
    logic [31:0] rdata_o, res_p, res_a;
    logic [1:0]  mod_bit, valid;
    logic        conv_reset, chop_phase;
    int          n_fail    = 0;
    int          compares  = 0;
    int          n;
    logic [15:0] fields [5] = '{16'h8000, 16'h4000, 16'h3F00, 16'h0080, 16'h007F};

    initial forever #2 sys_clk_i = ~sys_clk_i;
    srf_filter_ctrl #(.STARTUP_CYC(STARTUP)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .low_power_i(1'b0), .mod_bit_i(mod_bit), .chop_phase_o(chop_phase),
        .conv_reset_o(conv_reset), .result_primary_o(res_p), .result_aux_o(res_a),
        .result_valid_o(valid));
    srf_mod_model u_mod (.run_i(run), .mod_bit_o(mod_bit));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o === exp, "read data");
    endtask
    task automatic complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(conv_reset === 1'b1, "start-up");
        reg_rd(`SRF_FLT_CTRL_ADDR, 32'h0000_0007);
        reg_rd(32'hFFFF_0510, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_fields;
        foreach (fields[i]) begin
            reg_wr(`SRF_FLT_CTRL_ADDR, {16'hABCD, fields[i]});
            check(conv_reset === 1'b1, "restart on change");
            reg_rd(`SRF_FLT_CTRL_ADDR, {16'h0, fields[i]});
        end
        $display("test fields done");
    endtask
    task automatic t_same;
        repeat (STARTUP + 5) @(posedge sys_clk_i);
        check(conv_reset === 1'b0, "start-up end");
        reg_wr(`SRF_FLT_CTRL_ADDR, 32'h0000_007F);
        check(conv_reset === 1'b0, "same value write");
        reg_wr(`SRF_RESULT0_ADDR, 32'h0000_1234);
        reg_rd(`SRF_FLT_CTRL_ADDR, 32'h0000_007F);
        $display("test same done");
    endtask
    // Restart in mid-conversion, then time the first settled result
    task automatic t_conv;
        reg_wr(`SRF_FLT_CTRL_ADDR, 32'h0000_0001);
        repeat (2000) @(posedge sys_clk_i);
        run <= 1'b1;
        reg_wr(`SRF_FLT_CTRL_ADDR, 32'h0000_0000);
        check(chop_phase === 1'b0, "chop phase after restart");
        n = 0;
        while (valid === 2'h0 && n < 120000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check(n >= 92000 && n <= 96500, "settling time");
        check(valid === 2'h3, "both channels");
        check(res_p[31] === 1'b0 && res_p !== 32'h0, "primary sign");
        check(res_a[31] === 1'b1, "aux sign");
        $display("test conv done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        t_reset();
        t_fields();
        t_same();
        t_conv();
        complete_run();
    end
    initial begin
        repeat (150000) @(posedge sys_clk_i);
        n_fail++;
        $display("FAIL %0t timeout", $time);
        complete_run();
    end
endmodule // srf_filter_ctrl_tb_top
